// ---- src/atc_pkg.sv ----
// constants, field layout and states for the async transmit threshold control
// assumes a single 20 MHz core clock domain and byte-granular fifo levels
package atc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ATC_LEC_OFFSET = 8'hf4;
    localparam logic [31:0] ATC_LEC_RESET = 32'h00001000;
    localparam logic [31:0] ATC_LEC_WMASK = 32'h0000b000; // bits 15, 13, 12
    localparam logic [31:0] ATC_ZERO_WORD = 32'h00000000;
    localparam int ATC_BIT_NO_REORDER = 15;
    localparam int ATC_THR_HI = 13;
    localparam int ATC_THR_LO = 12;
    localparam int ATC_BE_LANE0 = 0;
    localparam int ATC_BE_LANE1 = 1;

    // ==========================================================
    // threshold field codes and byte counts
    localparam logic [1:0] ATC_THR_2K = 2'h0;
    localparam logic [1:0] ATC_THR_1K7 = 2'h1;
    localparam logic [1:0] ATC_THR_1K = 2'h2;
    localparam logic [1:0] ATC_THR_512 = 2'h3;
    localparam int ATC_BYTES_2K = 2048;
    localparam int ATC_BYTES_1K7 = 1740;
    localparam int ATC_BYTES_1K = 1024;
    localparam int ATC_BYTES_512 = 512;

    // ==========================================================
    // transmit sequence states
    typedef enum logic [2:0] {
        ATC_IDLE = 3'h0,
        ATC_SEND = 3'h1,
        ATC_REFILL = 3'h2,
        ATC_RESEND = 3'h3
    } atc_state_e;

endpackage : atc_pkg

// ---- src/atc_start_gate.sv ----
// start decision for one packet at the head of the transmit fifo
// assumes fill level and end-of-packet flag are from the core clock domain
`timescale 1ns/1ns
module atc_start_gate
    import atc_pkg::*;
#(
    parameter int LVL_W = 12
) (
    input wire logic [1:0] thr_field,
    input wire logic store_fwd,
    input wire logic [LVL_W-1:0] fill_bytes,
    input wire logic eop_in_fifo,
    output logic start_ok
);

    // ==========================================================
    // threshold decode
    function automatic logic [LVL_W-1:0] thr_bytes(input logic [1:0] code);
        case (code)
            ATC_THR_1K7: thr_bytes = LVL_W'(ATC_BYTES_1K7);
            ATC_THR_1K: thr_bytes = LVL_W'(ATC_BYTES_1K);
            ATC_THR_512: thr_bytes = LVL_W'(ATC_BYTES_512);
            default: thr_bytes = LVL_W'(ATC_BYTES_2K);
        endcase
    endfunction : thr_bytes

    // whole packet always starts; early start only below store-and-forward
    always_comb begin
        start_ok = eop_in_fifo;
        if (!store_fwd && thr_field != ATC_THR_2K && fill_bytes >= thr_bytes(thr_field)) begin
            start_ok = 1'b1;
        end
    end

endmodule : atc_start_gate

// ---- src/atc_tx_threshold.sv ----
// async transmit threshold control with its link enhancement register
// assumes fifo status, link status and retry info arrive on core_clk
// rst_b is the global reset pin; soft_rst is any lesser reset
// fifo status and the end token are level signals owned by the fifo control
// eop_in_fifo stays high from the end token until tx_done for that packet
// tx_done outranks an empty fifo, so a packet that just finished never underruns
// soft_rst leaves the register alone; only the pin restores its reset value
// the enhancement gate comes from the host controller control register
// every input here is already on core_clk, so none is resynchronised
// cfg_be lanes 2 and 3 reach only reserved bits and so change nothing
`timescale 1ns/1ns
module atc_tx_threshold
    import atc_pkg::*;
#(
    parameter int LVL_W = 12
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic soft_rst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata_r,
    output logic cfg_rvalid_r,
    input wire logic eeprom_load,
    input wire logic [15:0] eeprom_word,
    input wire logic phy_enhance_gate,
    input wire logic retries_zero,
    input wire logic pkt_ready,
    input wire logic [LVL_W-1:0] fifo_level,
    input wire logic eop_in_fifo,
    input wire logic fifo_empty,
    input wire logic tx_done,
    output logic tx_start_r,
    output logic tx_abort_r,
    output logic underrun_r,
    output logic retry_r,
    output logic store_fwd_r,
    output logic tx_reorder_en_r,
    output logic tx_busy_r
);

    // ==========================================================
    // register storage and next value
    logic [31:0] lec_r;
    logic [31:0] lec_nxt;
    logic [31:0] wr_mask;

    // register hit, shared by the read and write paths
    function automatic logic hits_lec(input logic [7:0] addr);
        hits_lec = addr == ATC_LEC_OFFSET;
    endfunction : hits_lec

    // byte-lane mask for host writes
    // bits outside the writable mask never hold a one, so no path can expose them
    always_comb begin
        wr_mask = ATC_ZERO_WORD;
        if (cfg_be[ATC_BE_LANE0]) begin
            wr_mask[7:0] = 8'hff;
        end
        if (cfg_be[ATC_BE_LANE1]) begin
            wr_mask[15:8] = 8'hff;
        end
        wr_mask = wr_mask & ATC_LEC_WMASK; // reserved bits stay zero
    end

    // host write wins over an eeprom load in the same cycle
    always_comb begin
        lec_nxt = lec_r;
        if (eeprom_load) begin
            lec_nxt = {16'h0000, eeprom_word} & ATC_LEC_WMASK;
        end
        if (cfg_wr && hits_lec(cfg_addr)) begin
            lec_nxt = (lec_r & ~wr_mask) | (cfg_wdata & wr_mask);
        end
    end

    // only the global reset pin resets the register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lec_r <= ATC_LEC_RESET;
        end else begin
            lec_r <= lec_nxt;
        end
    end

    // ==========================================================
    // register read port
    // read strobe answered one cycle later
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rvalid_r <= 1'b0;
        end else begin
            cfg_rvalid_r <= cfg_rd;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata_r <= ATC_ZERO_WORD;
        end else if (cfg_rd && hits_lec(cfg_addr)) begin
            cfg_rdata_r <= {16'h0000, lec_r[15:0]};
        end else if (cfg_rd) begin
            cfg_rdata_r <= ATC_ZERO_WORD; // unmapped reads as zero
        end
    end

    // ==========================================================
    // effective settings after the enhancement gate
    logic [1:0] eff_thr;
    logic eff_no_reorder;
    logic force_sf;

    // gate closed behaves as the reset value of the register
    always_comb begin
        eff_thr = ATC_THR_1K7;
        eff_no_reorder = 1'b0;
        if (phy_enhance_gate) begin
            eff_thr = lec_r[ATC_THR_HI:ATC_THR_LO];
            eff_no_reorder = lec_r[ATC_BIT_NO_REORDER];
        end
    end

    // a zero retry count or the 2K code both mean store-and-forward
    assign force_sf = retries_zero || eff_thr == ATC_THR_2K;

    // ==========================================================
    // transmit sequence
    atc_state_e state_r;
    atc_state_e state_nxt;
    logic start_ok;
    logic gate_sf;
    logic start_now;
    logic underrun_now;

    // refill and resend together make up the retry attempt
    // only the first attempt can underrun; the resend starts from a whole packet
    function automatic logic in_retry(input atc_state_e st);
        in_retry = st == ATC_REFILL || st == ATC_RESEND;
    endfunction : in_retry

    // retry attempt is always store-and-forward
    assign gate_sf = force_sf || state_r == ATC_REFILL;

    atc_start_gate #(
        .LVL_W(LVL_W)
    ) u_start_gate (
        .thr_field(eff_thr),
        .store_fwd(gate_sf),
        .fill_bytes(fifo_level),
        .eop_in_fifo(eop_in_fifo),
        .start_ok(start_ok)
    );

    // next state and event decode
    // tx_done is tested first so a finished packet never counts as an underrun
    // pkt_ready is ignored outside idle, so a refill cannot start a new packet
    always_comb begin
        state_nxt = state_r;
        start_now = 1'b0;
        underrun_now = 1'b0;
        case (state_r)
            ATC_IDLE: begin
                if (pkt_ready && start_ok) begin
                    state_nxt = ATC_SEND;
                    start_now = 1'b1;
                end
            end
            ATC_SEND: begin
                if (tx_done) begin
                    state_nxt = ATC_IDLE;
                end else if (fifo_empty && !eop_in_fifo) begin
                    state_nxt = ATC_REFILL;
                    underrun_now = 1'b1;
                end
            end
            ATC_REFILL: begin
                if (start_ok) begin
                    state_nxt = ATC_RESEND;
                    start_now = 1'b1;
                end
            end
            ATC_RESEND: begin
                if (tx_done) begin
                    state_nxt = ATC_IDLE;
                end
            end
            default: begin
                state_nxt = ATC_IDLE;
            end
        endcase
    end

    // state register; lesser resets restart the sequence
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ATC_IDLE;
        end else if (soft_rst) begin
            state_r <= ATC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // link-facing outputs
    // one-cycle start strobe, first attempt or retry
    // never two in a row, since a start always leaves idle or refill
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_start_r <= 1'b0;
        end else if (soft_rst) begin
            tx_start_r <= 1'b0;
        end else begin
            tx_start_r <= start_now;
        end
    end

    // errored-packet strobe toward the link
    // raised with the underrun so the far node sees a bad packet
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_abort_r <= 1'b0;
        end else if (soft_rst) begin
            tx_abort_r <= 1'b0;
        end else begin
            tx_abort_r <= underrun_now; // errored packet
        end
    end

    // underrun strobe, same cycle as the abort
    // kept apart from the abort so status logic can count underruns
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            underrun_r <= 1'b0;
        end else if (soft_rst) begin
            underrun_r <= 1'b0;
        end else begin
            underrun_r <= underrun_now;
        end
    end

    // retry level, high through refill and resend
    // tells the host side the second attempt is store-and-forward
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            retry_r <= 1'b0;
        end else if (soft_rst) begin
            retry_r <= 1'b0;
        end else begin
            retry_r <= in_retry(state_nxt);
        end
    end

    // store-and-forward in force, forced or during a retry
    // a lesser reset drops the retry but keeps the forced setting
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            store_fwd_r <= 1'b0;
        end else if (soft_rst) begin
            store_fwd_r <= force_sf;
        end else begin
            store_fwd_r <= force_sf || in_retry(state_nxt);
        end
    end

    // reorder permission, follows the gated register bit
    // reset value allows reordering, matching the bit's cleared state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_reorder_en_r <= 1'b1;
        end else begin
            tx_reorder_en_r <= !eff_no_reorder;
        end
    end

    // busy through a send or resend
    // drops the cycle after tx_done
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_busy_r <= 1'b0;
        end else if (soft_rst) begin
            tx_busy_r <= 1'b0;
        end else begin
            tx_busy_r <= state_nxt == ATC_SEND || state_nxt == ATC_RESEND;
        end
    end

endmodule : atc_tx_threshold

// ---- dv/atc_monitor.sv ----
// port assertions for the async transmit threshold control
// assumes one core clock and rst_b as its only asynchronous reset
`timescale 1ns/1ns
module atc_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_rdata_r,
    input wire logic cfg_rvalid_r,
    input wire logic retries_zero,
    input wire logic eop_in_fifo,
    input wire logic fifo_empty,
    input wire logic tx_done,
    input wire logic tx_start_r,
    input wire logic tx_abort_r,
    input wire logic underrun_r,
    input wire logic retry_r,
    input wire logic store_fwd_r,
    input wire logic tx_busy_r
);
    // ==========================================================
    // register and transmit checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid_r) else $error("no read answer");
    AST_RSVD_ZERO: assert property (cfg_rvalid_r |-> cfg_rdata_r[31:16] == 16'h0000)
        else $error("upper half not zero");
    AST_START_PULSE: assert property (tx_start_r |=> !tx_start_r) else $error("long start");
    AST_START_BUSY: assert property (tx_start_r |-> tx_busy_r) else $error("start idle");
    AST_ABORT_RETRY: assert property (tx_abort_r |-> underrun_r && retry_r && store_fwd_r)
        else $error("abort without retry");
    AST_UR_CAUSE: assert property (underrun_r |-> $past(fifo_empty && !eop_in_fifo && !tx_done))
        else $error("underrun without cause");
    AST_RESEND_WHOLE: assert property (tx_start_r && retry_r |-> $past(eop_in_fifo))
        else $error("resend before packet end");
    AST_SF_FORCE: assert property (retries_zero |=> store_fwd_r) else $error("no store fwd");
endmodule : atc_monitor

bind atc_tx_threshold atc_monitor u_mon (.core_clk, .rst_b, .cfg_rd, .cfg_rdata_r, .cfg_rvalid_r,
    .retries_zero, .eop_in_fifo, .fifo_empty, .tx_done, .tx_start_r, .tx_abort_r, .underrun_r,
    .retry_r, .store_fwd_r, .tx_busy_r);

// ---- dv/atc_fifo_model.sv ----
// fifo model: host fills four bytes a cycle, phy drains after start
// assumes the bench pulses load with a size and raises starve to stall
`timescale 1ns/1ns
module atc_fifo_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [11:0] size,
    input wire logic starve,
    input wire logic tx_start_r,
    input wire logic tx_abort_r,
    output logic pkt_ready,
    output logic [11:0] fifo_level,
    output logic eop_in_fifo,
    output logic fifo_empty,
    output logic tx_done
);
    logic pend, sent;
    logic [11:0] sz;
    logic [5:0] cnt;
    // ==========================================================
    // host side fill
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_level <= 12'h000;
            sz <= 12'h000;
            pend <= 1'b0;
        end else if (load) begin
            fifo_level <= 12'h000;
            sz <= size;
            pend <= 1'b1;
        end else if (tx_done) begin
            pend <= 1'b0;
        end else if (pend && !starve && fifo_level < sz) begin
            fifo_level <= fifo_level + 12'h004;
        end
    end
    // phy side drain, finishes forty cycles in once the end is held
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sent <= 1'b0;
            cnt <= 6'h00;
            tx_done <= 1'b0;
        end else begin
            tx_done <= sent && eop_in_fifo && cnt == 6'h28 && !tx_done;
            if (tx_start_r) begin
                sent <= 1'b1;
                cnt <= 6'h00;
            end else if (tx_abort_r || tx_done) begin
                sent <= 1'b0;
            end else if (sent && cnt != 6'h28) begin
                cnt <= cnt + 6'h01;
            end
        end
    end
    assign eop_in_fifo = pend && fifo_level >= sz;
    assign pkt_ready = pend && !sent;
    assign fifo_empty = sent && starve && !eop_in_fifo;
endmodule : atc_fifo_model

// ---- dv/atc_tx_threshold_test.sv ----
// register and transmit sequences for the threshold control
// assumes the fifo model stands at the far side of the fifo ports
`timescale 1ns/1ns
module atc_tx_threshold_test;
    import atc_pkg::*;
    logic core_clk, rst_b, soft_rst, cfg_wr, cfg_rd, eeprom_load, phy_enhance_gate;
    logic retries_zero, load, starve, cfg_rvalid_r, tx_start_r, tx_abort_r, underrun_r;
    logic retry_r, store_fwd_r, tx_reorder_en_r, tx_busy_r, pkt_ready, eop_in_fifo;
    logic fifo_empty, tx_done;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [15:0] eeprom_word;
    logic [11:0] fifo_level, size;
    logic [31:0] cfg_wdata, cfg_rdata_r;
    int bad_count, samples_checked, i;
    int thr[4] = '{2000, ATC_BYTES_1K7, ATC_BYTES_1K, ATC_BYTES_512};
    atc_tx_threshold u_atc_tx_threshold (.core_clk, .rst_b, .soft_rst, .cfg_wr, .cfg_rd,
        .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_r, .cfg_rvalid_r, .eeprom_load,
        .eeprom_word, .phy_enhance_gate, .retries_zero, .pkt_ready, .fifo_level, .eop_in_fifo,
        .fifo_empty, .tx_done, .tx_start_r, .tx_abort_r, .underrun_r, .retry_r, .store_fwd_r,
        .tx_reorder_en_r, .tx_busy_r);
    atc_fifo_model u_atc_fifo_model (.core_clk, .rst_b, .load, .size, .starve, .tx_start_r,
        .tx_abort_r, .pkt_ready, .fifo_level, .eop_in_fifo, .fifo_empty, .tx_done);
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        tick();
        cfg_wr = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        cfg_addr = a;
        cfg_rd = 1'b1;
        tick();
        cfg_rd = 1'b0;
        chk(32'(cfg_rvalid_r), 32'h1);
        chk(cfg_rdata_r, e);
        tick();
    endtask : rd
    // bounded wait on start (0), underrun (1) or idle (2)
    task automatic wt(input int n, input logic e, input int s);
        logic seen;
        int k;
        seen = 1'b0;
        for (k = 0; k < n && !seen; k++) begin
            tick();
            seen = s == 0 ? tx_start_r : s == 1 ? underrun_r : !tx_busy_r;
        end
        chk(32'(seen), 32'(e));
    endtask : wt
    task automatic pkt(input logic [1:0] c, input int cyc, input logic sf, input logic ur);
        wr(8'hf4, {18'h0, c, 12'h0});
        size = 12'd2000;
        load = 1'b1;
        tick();
        load = 1'b0;
        chk(32'(store_fwd_r), 32'(sf));
        wt(cyc - 3, 1'b0, 0);
        wt(8, 1'b1, 0);
        if (ur) begin
            starve = 1'b1;
            wt(6, 1'b1, 1);
            chk(32'(tx_abort_r), 32'h1);
            chk(32'(retry_r), 32'h1);
            starve = 1'b0;
            wt(55, 1'b0, 0);
            wt(20, 1'b1, 0);
        end
        wt(600, 1'b1, 2);
        chk(32'(retry_r), 32'h0);
    endtask : pkt
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // ==========================================================
    // clock, hang guard and main sequence
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end
    initial begin
        {rst_b, soft_rst, cfg_wr, cfg_rd, eeprom_load, retries_zero, load, starve} = 8'h00;
        {cfg_addr, eeprom_word, size, cfg_wdata} = 68'h0;
        phy_enhance_gate = 1'b1;
        cfg_be = 4'hf;
        repeat (16) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        rd(8'hf4, 32'h00001000);
        chk(32'(tx_reorder_en_r), 32'h1);
        wr(8'hf4, 32'hffffb000);
        wr(8'hf0, 32'hffffffff);
        rd(8'hf0, 32'h00000000);
        rd(8'hf4, 32'h0000b000);
        chk(32'(tx_reorder_en_r), 32'h0);
        cfg_be = 4'h1;
        wr(8'hf4, 32'h00000000);
        cfg_be = 4'hf;
        rd(8'hf4, 32'h0000b000);
        phy_enhance_gate = 1'b0;
        tick();
        tick();
        chk(32'(tx_reorder_en_r), 32'h1);
        pkt(2'h3, 435, 1'b0, 1'b0);
        phy_enhance_gate = 1'b1;
        soft_rst = 1'b1;
        tick();
        soft_rst = 1'b0;
        rd(8'hf4, 32'h00003000);
        for (i = 0; i < 4; i++) begin
            pkt(i[1:0], thr[i] / 4, i == 0, 1'b0);
        end
        retries_zero = 1'b1;
        pkt(2'h3, 500, 1'b1, 1'b0);
        retries_zero = 1'b0;
        pkt(2'h1, 435, 1'b0, 1'b1);
        eeprom_word = 16'h2000;
        eeprom_load = 1'b1;
        tick();
        eeprom_load = 1'b0;
        rd(8'hf4, 32'h00002000);
        rst_b = 1'b0;
        tick();
        rst_b = 1'b1;
        rd(8'hf4, 32'h00001000);
        stop_test();
    end
endmodule : atc_tx_threshold_test
